// >>> sfsr_pkg.sv
package sfsr_pkg;
  localparam int ADDR_W = 20;
  localparam int SECTOR_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_QE = 6;
  localparam int ST_LOCK = 7;
  localparam int FN_ERASE_SUSPENDED_FLAG = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
  localparam logic [7:0] STATUS_WR_MASK = 8'hFC;
  typedef enum logic [2:0] {
    SFSR_OP_NONE, SFSR_OP_WRITE_ENABLE_INSTRUCTION, SFSR_OP_WRITE_DISABLE_INSTRUCTION, SFSR_OP_STATUS_WRITE_INSTRUCTION,
    SFSR_OP_PROG, SFSR_OP_ERASE, SFSR_OP_CHIP
  } sfsr_op_t;
endpackage : sfsr_pkg

// >>> sfsr_addr_decode.sv
`timescale 1ns/1ns
module sfsr_addr_decode
  import sfsr_pkg::*;
(
  input wire logic [ADDR_W-1:0] byteAddr,
  input wire logic [3:0] protectBits,
  output logic [7:0] sectorIdx,
  output logic [4:0] block32Idx,
  output logic [3:0] block64Idx,
  output logic inProtected
);
  // Sixteen 4 KB sectors per 64 KB block, two 32 KB halves per block.
  assign sectorIdx = byteAddr[ADDR_W-1:SECTOR_LSB];
  assign block32Idx = byteAddr[ADDR_W-1:BLK32_LSB];
  assign block64Idx = byteAddr[ADDR_W-1:BLK64_LSB];

  // Protected region table: upper portions for codes 1..4, all for 5..10, lower for 11..14.
  always_comb begin
    case (protectBits)
      4'h0, 4'hF: inProtected = 1'b0;
      4'h1: inProtected = (block64Idx == 4'hF);
      4'h2: inProtected = (block64Idx >= 4'hE);
      4'h3: inProtected = (block64Idx >= 4'hC);
      4'h4: inProtected = (block64Idx >= 4'h8);
      4'hB: inProtected = (block64Idx <= 4'h7);
      4'hC: inProtected = (block64Idx <= 4'h3);
      4'hD: inProtected = (block64Idx <= 4'h1);
      4'hE: inProtected = (block64Idx == 4'h0);
      default: inProtected = 1'b1;
    endcase
  end
endmodule : sfsr_addr_decode

// >>> sfsr_regs.sv
`timescale 1ns/1ns
// How it works
// - Byte address splits into 4 KB sectors, 32 KB and 64 KB blocks.
// - Status bit 0 reads busy while program, erase or status write runs.
// - With write-enable latch clear, every write-type instruction is inhibited.
// - Write-enable instruction sets the latch; host must send it first.
// - Latch clears on write-disable and after any write-type operation completes.
// - Protection bits 5..2 block program or erase inside the protected region.
// - Whole-chip erase runs only when all protection bits are zero.
// - Lock bit set with protect pin low and quad-enable bit clear makes status writes ignored.
// - Quad-enable bit turns protect and hold pins into data lines 2 and 3.
// - Protection and lock bits change only by status write; status readable.
// - Status register reads zero as delivered.
// - Function register returned on the function read instruction.
// - Function bit 1 flags a suspended erase until it resumes.
// - Function bit 2 flags a suspended program until it resumes.
module sfsr_regs
  import sfsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic opDone,
  input wire logic suspendReq,
  input wire logic resumeReq,
  input wire logic statusReadReq,
  input wire logic functionReadReq,
  input wire logic writeProtectPin_n,
  input wire logic holdPin_n,
  output logic [7:0] readData,
  output logic readValid,
  output logic opStart,
  output logic opIsErase,
  output logic opRejected,
  output logic quadMode,
  output logic holdActive,
  output logic [7:0] flash_status_reg,
  output logic [7:0] suspend_flag_reg
);
  logic wpMeta, wpSync, holdMeta, holdSync;
  logic busy_flag, write_enable_latch, status_lock_bit, quad_enable_bit;
  logic [3:0] blockProtect;
  logic erase_suspended_flag, program_suspended_flag;
  logic opErase, opProgram;
  logic inProtected;
  logic cmdWrite, accept, statusLocked;
  sfsr_op_t op;

  sfsr_addr_decode uDecode (
    .byteAddr(cmdAddr),
    .protectBits(blockProtect),
    .sectorIdx(),
    .block32Idx(),
    .block64Idx(),
    .inProtected(inProtected)
  );

  // Pins come from outside the clock domain; only the second stage is read.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wpMeta <= 1'b1;
      wpSync <= 1'b1;
      holdMeta <= 1'b1;
      holdSync <= 1'b1;
    end else if (clkEn) begin
      wpMeta <= writeProtectPin_n;
      wpSync <= wpMeta;
      holdMeta <= holdPin_n;
      holdSync <= holdMeta;
    end
  end

  always_comb begin
    op = sfsr_op_t'(cmdOp);
    statusLocked = status_lock_bit && !wpSync && !quad_enable_bit;
    cmdWrite = (op == SFSR_OP_STATUS_WRITE_INSTRUCTION) || (op == SFSR_OP_PROG) || (op == SFSR_OP_ERASE)
      || (op == SFSR_OP_CHIP);
    accept = 1'b0;
    case (op)
      SFSR_OP_STATUS_WRITE_INSTRUCTION: accept = !statusLocked;
      SFSR_OP_PROG, SFSR_OP_ERASE: accept = !inProtected;
      SFSR_OP_CHIP: accept = (blockProtect == 4'h0);
      default: accept = 1'b0;
    endcase
    // A busy device or a clear latch takes no write-type instruction.
    accept = accept && cmdValid && write_enable_latch && !busy_flag;
  end

  // Busy covers the whole internal cycle.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_flag <= 1'b0;
      opErase <= 1'b0;
      opProgram <= 1'b0;
    end else if (clkEn) begin
      if (accept) begin
        busy_flag <= 1'b1;
        opErase <= (op == SFSR_OP_ERASE) || (op == SFSR_OP_CHIP);
        opProgram <= (op == SFSR_OP_PROG);
      end else if (opDone && busy_flag) begin
        busy_flag <= 1'b0;
        opErase <= 1'b0;
        opProgram <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      write_enable_latch <= 1'b0;
    end else if (clkEn) begin
      if (cmdValid && op == SFSR_OP_WRITE_ENABLE_INSTRUCTION && !busy_flag) begin
        write_enable_latch <= 1'b1;
      end else if (cmdValid && op == SFSR_OP_WRITE_DISABLE_INSTRUCTION && !busy_flag) begin
        write_enable_latch <= 1'b0;
      end else if (opDone && busy_flag) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // Stands in for the nonvolatile cells; only an accepted status write changes them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      blockProtect <= STATUS_RESET[ST_BP_HI:ST_BP_LO];
      quad_enable_bit <= STATUS_RESET[ST_QE];
      status_lock_bit <= STATUS_RESET[ST_LOCK];
    end else if (clkEn && accept && op == SFSR_OP_STATUS_WRITE_INSTRUCTION) begin
      blockProtect <= cmdData[ST_BP_HI:ST_BP_LO];
      quad_enable_bit <= cmdData[ST_QE];
      status_lock_bit <= cmdData[ST_LOCK];
    end
  end

  // Set wins over clear when suspend and resume coincide.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end else if (clkEn) begin
      if (suspendReq && busy_flag && opErase) begin
        erase_suspended_flag <= 1'b1;
      end else if (resumeReq) begin
        erase_suspended_flag <= 1'b0;
      end
      if (suspendReq && busy_flag && opProgram) begin
        program_suspended_flag <= 1'b1;
      end else if (resumeReq) begin
        program_suspended_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flash_status_reg <= STATUS_RESET;
      suspend_flag_reg <= FUNC_RESET;
      readData <= 8'h00;
      readValid <= 1'b0;
      opStart <= 1'b0;
      opIsErase <= 1'b0;
      opRejected <= 1'b0;
      quadMode <= 1'b0;
      holdActive <= 1'b0;
    end else if (clkEn) begin
      flash_status_reg <= {status_lock_bit, quad_enable_bit, blockProtect,
        write_enable_latch, busy_flag};
      suspend_flag_reg <= {5'h00, program_suspended_flag, erase_suspended_flag, 1'b0};
      readValid <= statusReadReq || functionReadReq;
      if (statusReadReq) begin
        readData <= {status_lock_bit, quad_enable_bit, blockProtect,
          write_enable_latch, busy_flag};
      end else if (functionReadReq) begin
        readData <= {5'h00, program_suspended_flag, erase_suspended_flag, 1'b0};
      end
      opStart <= accept;
      opIsErase <= accept && (op != SFSR_OP_PROG) && (op != SFSR_OP_STATUS_WRITE_INSTRUCTION);
      opRejected <= cmdValid && cmdWrite && !accept;
      quadMode <= quad_enable_bit;
      holdActive <= !quad_enable_bit && !holdSync;
    end
  end

  a_busy_rise: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn && accept |=> busy_flag && opStart) else $error("busy not raised");
  a_wel_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !write_enable_latch |-> !accept) else $error("write taken without latch");
  a_wel_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn && opDone && busy_flag && !accept |=> !write_enable_latch && !busy_flag)
    else $error("latch or busy not cleared");
  a_chip_prot: assert property (@(posedge clk_sys) disable iff (!resetn)
    op == SFSR_OP_CHIP && blockProtect != 4'h0 |-> !accept)
    else $error("chip erase under protection");
  a_region_prot: assert property (@(posedge clk_sys) disable iff (!resetn)
    (op == SFSR_OP_PROG || op == SFSR_OP_ERASE) && inProtected |-> !accept)
    else $error("protected area written");
  a_lock_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn && statusLocked |=> $stable(blockProtect) && $stable(status_lock_bit))
    else $error("locked status changed");
  a_func_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    suspend_flag_reg[7:3] == 5'h00 && !suspend_flag_reg[0])
    else $error("unused function bits set");
  a_erase_suspended_flag_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn && suspendReq && busy_flag && opErase |=> erase_suspended_flag ##1
    suspend_flag_reg[FN_ERASE_SUSPENDED_FLAG]) else $error("erase suspend not flagged");
  a_read_stat: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn && statusReadReq |=> readValid && readData[ST_WEL] == $past(write_enable_latch))
    else $error("status read wrong");
  // Covers mark the main scenarios: status write, erase, both suspends and a refusal.
  c_status_write_instruction: cover property (@(posedge clk_sys) accept && op == SFSR_OP_STATUS_WRITE_INSTRUCTION);
  c_prog_suspend: cover property (@(posedge clk_sys) program_suspended_flag);
  c_erase: cover property (@(posedge clk_sys) accept && op == SFSR_OP_ERASE);
  c_suspend: cover property (@(posedge clk_sys) erase_suspended_flag);
  c_reject: cover property (@(posedge clk_sys) opRejected);
endmodule : sfsr_regs

// >>> sfsr_array_model.sv
`timescale 1ns/1ns
module sfsr_array_model #(
  parameter int DONE_DLY = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic opStart,
  output logic opDone
);
  int cnt;
  // Real array cycles last milliseconds; a short fixed delay keeps the run brief.
  always @(negedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt = 0;
      opDone = 1'h0;
    end else begin
      opDone = (cnt == 1);
      if (opStart) cnt = DONE_DLY;
      else if (cnt > 0) cnt = cnt - 1;
    end
  end
endmodule : sfsr_array_model

// >>> serial_flash_status_function_regs_tb.sv
`timescale 1ns/1ns
module serial_flash_status_function_regs_tb;
  import sfsr_pkg::*;
  logic clk_sys = 1'h0, resetn = 1'h0, cmdValid = 1'h0, suspendReq = 1'h0, resumeReq = 1'h0;
  logic statusReadReq = 1'h0, functionReadReq = 1'h0, writeProtectPin_n = 1'h1;
  logic holdPin_n = 1'h1, opDone, readValid, opStart, opIsErase, opRejected, quadMode;
  logic holdActive, st, rj, er, clkEn = 1'h1;
  logic [2:0] cmdOp = 3'h0;
  logic [ADDR_W-1:0] cmdAddr = 20'h00000, decAddr = 20'h00000;
  logic [7:0] cmdData = 8'h00, readData, flash_status_reg, suspend_flag_reg;
  logic [7:0] seed = 8'h43, bp;
  int errCount = 0, samplesChecked = 0;
  always #5 clk_sys = ~clk_sys;
  sfsr_regs u_sfsr_regs (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .opDone(opDone), .suspendReq(suspendReq), .resumeReq(resumeReq),
    .statusReadReq(statusReadReq), .functionReadReq(functionReadReq),
    .writeProtectPin_n(writeProtectPin_n), .holdPin_n(holdPin_n), .readData(readData),
    .readValid(readValid), .opStart(opStart), .opIsErase(opIsErase), .opRejected(opRejected),
    .quadMode(quadMode), .holdActive(holdActive), .flash_status_reg(flash_status_reg),
    .suspend_flag_reg(suspend_flag_reg));
  sfsr_array_model u_sfsr_array_model (.clk_sys(clk_sys), .resetn(resetn),
    .opStart(opStart), .opDone(opDone));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : testDone
  task automatic cmd(input sfsr_op_t op, input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cmdValid = 1'h1;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    @(negedge clk_sys);
    cmdValid = 1'h0;
    st = opStart;
    rj = opRejected;
    er = opIsErase;
  endtask : cmd
  task automatic wrOp(input sfsr_op_t op, input logic [19:0] a, input logic [7:0] d);
    cmd(SFSR_OP_WRITE_ENABLE_INSTRUCTION, 20'h00000, 8'h00);
    cmd(op, a, d);
  endtask : wrOp
  task automatic rdChk(input logic fn, input logic [7:0] exp);
    @(negedge clk_sys);
    statusReadReq = !fn;
    functionReadReq = fn;
    @(negedge clk_sys);
    check("readValid", readValid, 1'h1);
    check(fn ? "funcReg" : "statusReg", readData, exp);
    check(fn ? "funcOut" : "statusOut", fn ? suspend_flag_reg : flash_status_reg, exp);
    statusReadReq = 1'h0;
    functionReadReq = 1'h0;
  endtask : rdChk
  task automatic pulse(input logic resume);
    @(negedge clk_sys);
    suspendReq = !resume;
    resumeReq = resume;
    @(negedge clk_sys);
    suspendReq = 1'h0;
    resumeReq = 1'h0;
  endtask : pulse
  task automatic waitIdle();
    repeat (2) @(negedge clk_sys);
    for (int i = 0; i < 60 && flash_status_reg[ST_BUSY] !== 1'h0; i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask : waitIdle
  initial begin
    #200000;
    errCount++;
    testDone();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'h1;
    rdChk(1'h0, 8'h00);
    rdChk(1'h1, 8'h00);
    cmd(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, 8'h3C);
    check("rejNoLatch", rj, 1'h1);
    cmd(SFSR_OP_WRITE_ENABLE_INSTRUCTION, 20'h00000, 8'h00);
    rdChk(1'h0, 8'h02);
    cmd(SFSR_OP_WRITE_DISABLE_INSTRUCTION, 20'h00000, 8'h00);
    rdChk(1'h0, 8'h00);
    // With the clock enable low a write-enable must leave every state bit alone.
    clkEn = 1'h0;
    cmd(SFSR_OP_WRITE_ENABLE_INSTRUCTION, 20'h00000, 8'h00);
    @(negedge clk_sys);
    clkEn = 1'h1;
    rdChk(1'h0, 8'h00);
    repeat (6) begin
      seed = lfsr(seed);
      bp = seed & 8'h3C;
      wrOp(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, seed & 8'h3F);
      check("wrsrStart", st, 1'h1);
      repeat (2) @(negedge clk_sys);
      check("busy", flash_status_reg[ST_BUSY], 1'h1);
      waitIdle();
      rdChk(1'h0, bp);
      wrOp(SFSR_OP_CHIP, 20'h00000, 8'h00);
      check("chipRej", rj, bp != 8'h00);
      if (st === 1'h1) waitIdle();
    end
    wrOp(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, 8'h04);
    waitIdle();
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      decAddr = (i == 0) ? 20'h10000 : (i == 1) ? 20'hF0000 : {seed, seed[3:0], lfsr(seed)};
      wrOp(SFSR_OP_PROG, decAddr, 8'h00);
      check("sector", u_sfsr_regs.uDecode.sectorIdx, decAddr[19:12]);
      check("blk32", u_sfsr_regs.uDecode.block32Idx, decAddr[19:15]);
      check("blk64", u_sfsr_regs.uDecode.block64Idx, decAddr[19:16]);
      check("inProt", rj, decAddr[19:16] == 4'hF);
      if (st === 1'h1) waitIdle();
    end
    wrOp(SFSR_OP_PROG, 20'hF0123, 8'h00);
    check("protRej", rj, 1'h1);
    wrOp(SFSR_OP_PROG, 20'hEFFFF, 8'h00);
    check("progStart", st, 1'h1);
    pulse(1'h0);
    rdChk(1'h1, 8'h04);
    pulse(1'h1);
    rdChk(1'h1, 8'h00);
    waitIdle();
    wrOp(SFSR_OP_ERASE, 20'h01000, 8'h00);
    check("eraseFlag", er, 1'h1);
    pulse(1'h0);
    rdChk(1'h1, 8'h02);
    pulse(1'h1);
    rdChk(1'h1, 8'h00);
    waitIdle();
    wrOp(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, 8'h80);
    waitIdle();
    writeProtectPin_n = 1'h0;
    holdPin_n = 1'h0;
    wrOp(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, 8'h00);
    check("lockRej", rj, 1'h1);
    check("holdOn", holdActive, 1'h1);
    writeProtectPin_n = 1'h1;
    repeat (3) @(negedge clk_sys);
    // The bench drives both pins, so none is tied when quad mode is switched on.
    wrOp(SFSR_OP_STATUS_WRITE_INSTRUCTION, 20'h00000, 8'h40);
    check("lockOpen", st, 1'h1);
    waitIdle();
    rdChk(1'h0, 8'h40);
    check("quad", quadMode, 1'h1);
    check("holdOff", holdActive, 1'h0);
    testDone();
  end
endmodule : serial_flash_status_function_regs_tb
